//--- design/pcr_regs.sv
`timescale 1ns/1ns
// What this block does
// RL1: host writes reserved fields with defaults; stored as written.
// RL2: stamp control bit 1 selects pecl receiver mode, ground termination.
// RL3: stamp control bit 0 enables stamp receiver; register resets to zero.
// RL4: reference clock output on only when its bit and synth enable set.
// RL5: second divider bits 3:2: codes 0,1,2 give 1,2,4; 3 reserved.
// RL6: first divider bits 1:0: codes 0,1,2 give 5,4,3; 3 reserved.
// RL7: third divider bits 5:0 is ratio 1..63 directly; resets to 32.
// RL8: host asserts synth reset before changing any divider field.
// RL9: oscillator bias seven bits, resets 0x4f; 0x4a recommended.
// RL10: host programs oscillator bias 0x4a when synthesizer used.
// RL11: divider values reach synth dividers only while synth reset asserted.
module pcr_regs
  import pcr_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       wr_en_i,
  input  wire logic       rd_en_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       synth_enable_i,
  input  wire logic       synth_reset_i,
  output logic      [7:0] rdata_o,
  output logic            rvalid_o,
  output logic            stamp_input_enable_o,
  output logic            stamp_input_pecl_mode_o,
  output logic            ref_clock_output_enable_o,
  output logic      [2:0] first_ratio_o,
  output logic      [2:0] second_ratio_o,
  output logic      [5:0] third_ratio_o,
  output logic            divider_code_reserved_o,
  output logic      [6:0] oscillator_bias_o,
  output logic            bias_not_recommended_o
);
  // =====================================================
  // register state
  logic [7:0] stamp_ctrl_reg;
  logic [7:0] stamp_ctrl_next;
  logic [7:0] ref_ctrl_reg;
  logic [7:0] ref_ctrl_next;
  logic [7:0] fbdiv_a_reg;
  logic [7:0] fbdiv_a_next;
  logic [7:0] fbdiv_b_reg;
  logic [7:0] fbdiv_b_next;
  logic [7:0] osc_bias_reg;
  logic [7:0] osc_bias_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       rvalid_reg;
  logic       rvalid_next;

  always_comb
  begin
    stamp_ctrl_next = stamp_ctrl_reg;
    ref_ctrl_next   = ref_ctrl_reg;
    fbdiv_a_next    = fbdiv_a_reg;
    fbdiv_b_next    = fbdiv_b_reg;
    osc_bias_next   = osc_bias_reg;
    if (wr_en_i)
    begin
      unique case (addr_i) // RL1
        PCR_ADDR_STAMP_CTRL: stamp_ctrl_next = wdata_i;
        PCR_ADDR_REF_CTRL:   ref_ctrl_next   = wdata_i;
        PCR_ADDR_FBDIV_A:    fbdiv_a_next    = wdata_i;
        PCR_ADDR_FBDIV_B:    fbdiv_b_next    = wdata_i;
        PCR_ADDR_OSC_BIAS:   osc_bias_next   = wdata_i; // RL9
        default:             stamp_ctrl_next = stamp_ctrl_reg;
      endcase
    end
    rvalid_next = rd_en_i;
    rdata_next  = 8'h00;
    if (rd_en_i)
    begin
      unique case (addr_i)
        PCR_ADDR_STAMP_CTRL: rdata_next = stamp_ctrl_reg;
        PCR_ADDR_REF_CTRL:   rdata_next = ref_ctrl_reg;
        PCR_ADDR_FBDIV_A:    rdata_next = fbdiv_a_reg;
        PCR_ADDR_FBDIV_B:    rdata_next = fbdiv_b_reg;
        PCR_ADDR_OSC_BIAS:   rdata_next = osc_bias_reg;
        default:             rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      stamp_ctrl_reg <= PCR_RST_STAMP_CTRL; // RL3
      ref_ctrl_reg   <= PCR_RST_REF_CTRL; // RL4
      fbdiv_a_reg    <= PCR_RST_FBDIV_A;
      fbdiv_b_reg    <= PCR_RST_FBDIV_B; // RL7
      osc_bias_reg   <= PCR_RST_OSC_BIAS; // RL9
      rdata_reg      <= 8'h00;
      rvalid_reg     <= 1'b0;
    end
    else
    begin
      stamp_ctrl_reg <= stamp_ctrl_next;
      ref_ctrl_reg   <= ref_ctrl_next;
      fbdiv_a_reg    <= fbdiv_a_next;
      fbdiv_b_reg    <= fbdiv_b_next;
      osc_bias_reg   <= osc_bias_next;
      rdata_reg      <= rdata_next;
      rvalid_reg     <= rvalid_next;
    end
  end

  // =====================================================
  // external pin synchronisers
  logic [1:0] en_sync_reg, en_sync_next;
  logic [1:0] rst_sync_reg, rst_sync_next;

  always_comb
  begin
    en_sync_next  = {en_sync_reg[0], synth_enable_i};
    rst_sync_next = {rst_sync_reg[0], synth_reset_i};
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      en_sync_reg  <= 2'b00;
      rst_sync_reg <= 2'b00;
    end
    else
    begin
      en_sync_reg  <= en_sync_next;
      rst_sync_reg <= rst_sync_next;
    end
  end

  // =====================================================
  // decoded divider ratios
  logic [2:0] first_dec, second_dec;
  logic       code_res_dec;

  pcr_ratio_decode u_decode (
    .first_code_i    (fbdiv_a_reg[PCR_FIRST_LSB +: 2]),
    .second_code_i   (fbdiv_a_reg[PCR_SECOND_LSB +: 2]),
    .first_ratio_o   (first_dec),
    .second_ratio_o  (second_dec),
    .code_reserved_o (code_res_dec)
  );

  // =====================================================
  // control outputs
  logic       stamp_en_reg;
  logic       stamp_en_next;
  logic       pecl_reg;
  logic       pecl_next;
  logic       ref_out_reg;
  logic       ref_out_next;
  logic [2:0] first_reg;
  logic [2:0] first_next;
  logic [2:0] second_reg;
  logic [2:0] second_next;
  logic [5:0] third_reg;
  logic [5:0] third_next;
  logic       res_reg;
  logic       res_next;
  logic [6:0] bias_reg;
  logic [6:0] bias_next;
  logic       bias_warn_reg;
  logic       bias_warn_next;

  always_comb
  begin
    stamp_en_next = stamp_ctrl_reg[PCR_BIT_STAMP_EN]; // RL3
    pecl_next     = stamp_ctrl_reg[PCR_BIT_STAMP_PECL]; // RL2
    ref_out_next  = ref_ctrl_reg[PCR_BIT_REF_EN] && en_sync_reg[1]; // RL4
    first_next    = first_reg;
    second_next   = second_reg;
    third_next    = third_reg;
    res_next      = res_reg;
    if (rst_sync_reg[1]) // RL11
    begin
      first_next  = first_dec; // RL6
      second_next = second_dec; // RL5
      third_next  = fbdiv_b_reg[PCR_THIRD_LSB +: 6]; // RL7
      res_next    = code_res_dec;
    end
    bias_next      = osc_bias_reg[PCR_BIAS_LSB +: 7];
    bias_warn_next = en_sync_reg[1]
                   && (bias_next != PCR_OSC_BIAS_RECOMMENDED); // RL10
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      stamp_en_reg  <= 1'b0;
      pecl_reg      <= 1'b0;
      ref_out_reg   <= 1'b0;
      first_reg     <= PCR_FIRST_R0;
      second_reg    <= PCR_SECOND_R0;
      third_reg     <= PCR_RST_FBDIV_B[5:0];
      res_reg       <= 1'b0;
      bias_reg      <= PCR_RST_OSC_BIAS[6:0];
      bias_warn_reg <= 1'b0;
    end
    else
    begin
      stamp_en_reg  <= stamp_en_next;
      pecl_reg      <= pecl_next;
      ref_out_reg   <= ref_out_next;
      first_reg     <= first_next;
      second_reg    <= second_next;
      third_reg     <= third_next;
      res_reg       <= res_next;
      bias_reg      <= bias_next;
      bias_warn_reg <= bias_warn_next;
    end
  end

  assign rdata_o                   = rdata_reg;
  assign rvalid_o                  = rvalid_reg;
  assign stamp_input_enable_o      = stamp_en_reg;
  assign stamp_input_pecl_mode_o   = pecl_reg;
  assign ref_clock_output_enable_o = ref_out_reg;
  assign first_ratio_o             = first_reg;
  assign second_ratio_o            = second_reg;
  assign third_ratio_o             = third_reg;
  assign divider_code_reserved_o   = res_reg;
  assign oscillator_bias_o         = bias_reg;
  assign bias_not_recommended_o    = bias_warn_reg;
endmodule

//--- design/pcr_pkg.sv
package pcr_pkg;
  // =====================================================
  // register offsets
  localparam logic [7:0] PCR_ADDR_STAMP_CTRL = 8'h3b;
  localparam logic [7:0] PCR_ADDR_REF_CTRL   = 8'h3c;
  localparam logic [7:0] PCR_ADDR_FBDIV_A    = 8'h3d;
  localparam logic [7:0] PCR_ADDR_FBDIV_B    = 8'h3e;
  localparam logic [7:0] PCR_ADDR_OSC_BIAS   = 8'h3f;
  // =====================================================
  // reset values and recommended oscillator bias
  localparam logic [7:0] PCR_RST_STAMP_CTRL = 8'h00;
  localparam logic [7:0] PCR_RST_REF_CTRL   = 8'h01;
  localparam logic [7:0] PCR_RST_FBDIV_A    = 8'h00;
  localparam logic [7:0] PCR_RST_FBDIV_B    = 8'h20;
  localparam logic [7:0] PCR_RST_OSC_BIAS   = 8'h4f;
  localparam logic [6:0] PCR_OSC_BIAS_RECOMMENDED = 7'h4a;
  // =====================================================
  // field positions
  localparam int PCR_BIT_STAMP_EN   = 0;
  localparam int PCR_BIT_STAMP_PECL = 1;
  localparam int PCR_BIT_REF_EN     = 0;
  localparam int PCR_FIRST_LSB      = 0;
  localparam int PCR_SECOND_LSB     = 2;
  localparam int PCR_THIRD_LSB      = 0;
  localparam int PCR_BIAS_LSB       = 0;
  // =====================================================
  // divider ratio codes
  localparam logic [1:0] PCR_CODE_RESERVED = 2'h3;
  localparam logic [2:0] PCR_FIRST_R0  = 3'h5;
  localparam logic [2:0] PCR_FIRST_R1  = 3'h4;
  localparam logic [2:0] PCR_FIRST_R2  = 3'h3;
  localparam logic [2:0] PCR_SECOND_R0 = 3'h1;
  localparam logic [2:0] PCR_SECOND_R1 = 3'h2;
  localparam logic [2:0] PCR_SECOND_R2 = 3'h4;
  localparam logic [2:0] PCR_RATIO_NONE = 3'h0;
  localparam logic [5:0] PCR_THIRD_NONE = 6'h00;
endpackage

//--- design/pcr_ratio_decode.sv
`timescale 1ns/1ns
// =====================================================
// feedback divider code to ratio decode
module pcr_ratio_decode
  import pcr_pkg::*;
(
  input  wire logic [1:0] first_code_i,
  input  wire logic [1:0] second_code_i,
  output logic      [2:0] first_ratio_o,
  output logic      [2:0] second_ratio_o,
  output logic            code_reserved_o
);
  always_comb
  begin
    unique case (first_code_i) // RL6
      2'h0:    first_ratio_o = PCR_FIRST_R0;
      2'h1:    first_ratio_o = PCR_FIRST_R1;
      2'h2:    first_ratio_o = PCR_FIRST_R2;
      default: first_ratio_o = PCR_RATIO_NONE;
    endcase
    unique case (second_code_i) // RL5
      2'h0:    second_ratio_o = PCR_SECOND_R0;
      2'h1:    second_ratio_o = PCR_SECOND_R1;
      2'h2:    second_ratio_o = PCR_SECOND_R2;
      default: second_ratio_o = PCR_RATIO_NONE;
    endcase
    code_reserved_o = (first_code_i == PCR_CODE_RESERVED)
                    || (second_code_i == PCR_CODE_RESERVED);
  end
endmodule

//--- tb/pcr_asserts.sv
`timescale 1ns/1ns
// ======
// register block checks
module pcr_asserts
  import pcr_pkg::*;
(
  input wire logic       sys_clk_i,
  input wire logic       resetn_i,
  input wire logic       wr_en_i,
  input wire logic       rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       synth_enable_i,
  input wire logic       synth_reset_i,
  input wire logic [7:0] rdata_o,
  input wire logic       rvalid_o,
  input wire logic       stamp_input_enable_o,
  input wire logic       stamp_input_pecl_mode_o,
  input wire logic       ref_clock_output_enable_o,
  input wire logic [2:0] first_ratio_o,
  input wire logic [2:0] second_ratio_o,
  input wire logic [5:0] third_ratio_o,
  input wire logic [6:0] oscillator_bias_o,
  input wire logic       bias_not_recommended_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);
  function automatic logic [5:0] ratios(input logic [3:0] c);
    return {c[1] ? (c[0] ? 3'h0 : 3'h3) : (c[0] ? 3'h4 : 3'h5),
            c[3] ? (c[2] ? 3'h0 : 3'h4) : (c[2] ? 3'h2 : 3'h1)};
  endfunction
  sequence sync_hi;
    synth_reset_i [*3];
  endsequence
  sequence wr_to(a);
    wr_en_i && addr_i == a;
  endsequence
  stamp_en_a: assert property (
    wr_to(8'h3b) |-> ##2 stamp_input_enable_o == $past(wdata_i[0], 2))
    else $error("stamp enable wrong");
  pecl_mode_a: assert property (
    wr_to(8'h3b) |-> ##2 stamp_input_pecl_mode_o == $past(wdata_i[1], 2))
    else $error("pecl mode wrong");
  ref_gate_a: assert property (
    ref_clock_output_enable_o |-> $past(synth_enable_i, 3))
    else $error("ref output on without enable");
  rd_valid_a: assert property (rd_en_i |=> rvalid_o)
    else $error("read not answered");
  rd_idle_a: assert property (
    !rd_en_i |=> !rvalid_o && rdata_o == 8'h00)
    else $error("read data without read");
  div_map_a: assert property (
    sync_hi ##0 wr_to(8'h3d) |-> ##2
    {first_ratio_o, second_ratio_o} == ratios($past(wdata_i[3:0], 2)))
    else $error("divider ratio wrong");
  third_map_a: assert property (
    sync_hi ##0 wr_to(8'h3e) |-> ##2 third_ratio_o == $past(wdata_i[5:0], 2))
    else $error("third ratio wrong");
  div_hold_a: assert property (
    !synth_reset_i [*4] |=> $stable(first_ratio_o) && $stable(third_ratio_o))
    else $error("divider changed outside synth reset");
  bias_out_a: assert property (
    wr_to(8'h3f) |-> ##2 oscillator_bias_o == $past(wdata_i[6:0], 2))
    else $error("oscillator bias wrong");
  bias_warn_a: assert property (
    bias_not_recommended_o |->
    $past(synth_enable_i, 3) && oscillator_bias_o != PCR_OSC_BIAS_RECOMMENDED)
    else $error("bias warning without cause");
endmodule

//--- tb/pcr_host.sv
`timescale 1ns/1ns
// ======
// serial host stand-in
module pcr_host
(
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  output logic            wr_en_o,
  output logic            rd_en_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            synth_reset_o
);
  initial {wr_en_o, rd_en_o, addr_o, wdata_o, synth_reset_o} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    {wr_en_o, addr_o, wdata_o} = {1'b1, a, d};
    @(posedge clk_i);
    #1;
    wr_en_o = 1'b0;
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [8:0] q);
    @(posedge clk_i);
    #1;
    {rd_en_o, addr_o} = {1'b1, a};
    @(posedge clk_i);
    #1;
    rd_en_o = 1'b0;
    q = {rvalid_i, rdata_i};
  endtask
  // divider write under synth reset
  task automatic wr_div(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    synth_reset_o = 1'b1;
    repeat (3) @(posedge clk_i);
    wr(a, d);
    @(posedge clk_i);
    #1;
    synth_reset_o = 1'b0;
  endtask
endmodule

//--- tb/pcr_regs_tb.sv
`timescale 1ns/1ns
// ======
// register block bench
module pcr_regs_tb;
  import pcr_pkg::*;
  logic       sys_clk_i, resetn_i, synth_enable_i, wr_en, rd_en, srst;
  logic       rvalid, stamp_en, pecl, ref_en, resv, bias_warn;
  logic [6:0] bias;
  logic [7:0] addr, wdata, rdata;
  logic [2:0] first, second;
  logic [5:0] third;
  logic [8:0] q;
  logic [7:0] rst [5] = '{8'h00, 8'h01, 8'h00, 8'h20, 8'h4f};
  logic [5:0] rat [4] = '{6'h29, 6'h22, 6'h1c, 6'h00};
  int         err_total = 0;
  int         n_checks = 0;
  pcr_regs uut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .wr_en_i(wr_en),
    .rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata),
    .synth_enable_i(synth_enable_i), .synth_reset_i(srst), .rdata_o(rdata),
    .rvalid_o(rvalid), .stamp_input_enable_o(stamp_en),
    .stamp_input_pecl_mode_o(pecl), .ref_clock_output_enable_o(ref_en),
    .first_ratio_o(first), .second_ratio_o(second), .third_ratio_o(third),
    .divider_code_reserved_o(resv), .oscillator_bias_o(bias),
    .bias_not_recommended_o(bias_warn));
  pcr_host host (.clk_i(sys_clk_i), .rdata_i(rdata), .rvalid_i(rvalid),
    .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr), .wdata_o(wdata),
    .synth_reset_o(srst));
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic t_reset;
    for (int i = 0; i < 5; i++)
    begin
      host.rd(8'h3b + 8'(i), q);
      chk(q, {1'b1, rst[i]});
    end
    chk({ref_en, stamp_en, pecl, first, second}, {3'h0, 6'h29});
    chk(third, 9'h020);
    chk({bias_warn, bias}, {1'b0, 7'h4f});
  endtask
  task automatic t_stamp;
    for (int v = 0; v < 4; v++)
    begin
      host.wr(PCR_ADDR_STAMP_CTRL, 8'(v));
      @(posedge sys_clk_i);
      #1;
      chk({pecl, stamp_en}, 9'(v));
    end
    host.rd(PCR_ADDR_STAMP_CTRL, q);
    chk(q, 9'h103);
  endtask
  task automatic t_ref;
    synth_enable_i = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk(ref_en, 1'b1);
    host.wr(PCR_ADDR_REF_CTRL, 8'h00);
    @(posedge sys_clk_i);
    #1;
    chk(ref_en, 1'b0);
    host.wr(PCR_ADDR_REF_CTRL, 8'h01);
    synth_enable_i = 1'b0;
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk(ref_en, 1'b0);
  endtask
  task automatic t_div;
    for (int c = 0; c < 4; c++)
    begin
      host.wr_div(PCR_ADDR_FBDIV_A, 8'(c * 5));
      chk({resv, first, second}, {c == 3, rat[c]});
    end
    host.wr_div(PCR_ADDR_FBDIV_B, 8'h01);
    chk(third, 9'h001);
    host.wr_div(PCR_ADDR_FBDIV_B, 8'h3f);
    chk(third, 9'h03f);
    repeat (4) @(posedge sys_clk_i);
    host.wr(PCR_ADDR_FBDIV_B, 8'h05);
    repeat (4) @(posedge sys_clk_i);
    #1;
    chk(third, 9'h03f);
  endtask
  task automatic t_misc;
    host.rd(8'h40, q);
    chk(q, 9'h100);
    synth_enable_i = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk({bias_warn, bias}, {1'b1, 7'h4f});
    host.wr(PCR_ADDR_OSC_BIAS, 8'h4a);
    host.rd(PCR_ADDR_OSC_BIAS, q);
    chk(q, 9'h14a);
    chk({bias_warn, bias}, {1'b0, 7'h4a});
  endtask
  initial
  begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  initial
  begin
    repeat (5000) @(posedge sys_clk_i);
    err_total++;
    close_out();
  end
  initial
  begin
    resetn_i = 1'b0;
    synth_enable_i = 1'b0;
    repeat (16) @(posedge sys_clk_i);
    #1;
    resetn_i = 1'b1;
    t_reset();
    t_stamp();
    t_ref();
    t_div();
    t_misc();
    close_out();
  end
endmodule
bind pcr_regs pcr_asserts asrt (.*);
